// ---- common/quad_counter_pkg.sv ----
`default_nettype none
package quad_counter_pkg;

   // register indices on the byte link
   localparam logic [3:0] REG_MODE_ZERO    = 4'h0;
   localparam logic [3:0] REG_COUNT_SETUP  = 4'h1;
   localparam logic [3:0] REG_FLAG_SELECT  = 4'h2;
   localparam logic [3:0] REG_PRESET_LOW   = 4'h3;
   localparam logic [3:0] REG_PRESET_HIGH  = 4'h4;
   localparam logic [3:0] REG_COMMAND      = 4'h5;
   localparam logic [3:0] REG_CAPTURE      = 4'h6;
   localparam logic [3:0] REG_COUNT_VALUE  = 4'h7;
   localparam logic [3:0] REG_SNAPSHOT     = 4'h8;
   localparam logic [3:0] REG_LIVE_STATUS  = 4'h9;

   // count_setup fields
   localparam int SETUP_WIDTH_LSB = 0;
   localparam int SETUP_GATE      = 2;
   localparam int SETUP_CLR_RD    = 6;
   localparam int SETUP_NO_SNAP   = 7;

   // flag_select fields
   localparam int FLAG_EVENT_MSB  = 4;
   localparam int FLAG_MH_TGL     = 5;
   localparam int FLAG_BW_TGL     = 6;
   localparam int FLAG_DIR        = 7;
   localparam logic [7:0] FLAG_DIR_ONLY = 8'h80;

   // command_strobe bits
   localparam int CMD_CLR_COUNT   = 0;
   localparam int CMD_LOAD_LOW    = 1;
   localparam int CMD_LOAD_HIGH   = 2;
   localparam int CMD_CAPTURE     = 3;
   localparam int CMD_SNAPSHOT    = 4;
   localparam int CMD_CLR_STATUS  = 5;
   localparam int CMD_MASTER      = 7;

   // live and snapshot status bits
   localparam int ST_POWER_LOSS   = 0;
   localparam int ST_GATE         = 1;
   localparam int ST_INDEX        = 2;
   localparam int ST_MATCH_LOW    = 3;
   localparam int ST_MATCH_HIGH   = 4;
   localparam int ST_BORROW       = 5;
   localparam int ST_CARRY        = 6;
   localparam int ST_DIR          = 7;

   // values after reset, and the full width mask
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [31:0] FULL_MASK  = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      MODE_FREE  = 2'h0,
      MODE_NOREC = 2'h1,
      MODE_RANGE = 2'h2,
      MODE_MODN  = 2'h3
   } count_mode_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       first;
      logic [3:0] addr;
      logic [7:0] wdata;
   } link_req_t;

   typedef struct packed {
      logic [7:0]  count_setup;
      logic [7:0]  flag_select;
      logic [31:0] preset_low;
      logic [31:0] preset_high;
      logic [31:0] count_capture;
      logic [31:0] count_core;
      logic [7:0]  live_status;
      logic [7:0]  snapshot_status;
      logic [31:0] shadow;
      logic [1:0]  idx;
      logic [7:0]  cmd;
      logic        cmd_pend;
      logic        frozen;
      logic        match_high_toggle;
      logic        borrow_toggle;
      logic        pulsed_active;
      logic        latched;
      logic [7:0]  rdata;
      logic        req_s1;
      logic        req_s2;
      logic        ack_tgl;
   } core_state_t;

   typedef struct packed {
      link_req_t  req;
      logic       req_tgl;
      logic       ack_s1;
      logic       ack_s2;
      logic       ack_seen;
      logic [7:0] rdata;
      logic       done;
   } link_state_t;

endpackage
`default_nettype wire

// ---- logic/quad_counter_register_control.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - setup bits 1:0 pick four, three, two or one byte register width
// - setup bit 2 high stops counting, low lets the counter count
// - setup bit 6 high: reading the counter clears live status
// - setup bit 7 low: reading the counter copies live into snapshot status
// - with both read options, copy to snapshot first, then clear live status
// - reset zeroes setup, flag select, both status, low preset, capture
// - flag select bits 0-4 enable carry, borrow, match low, match high, index
// - flag bit 5 toggles a level on each match high while counting up
// - flag bit 6 toggles a level on every borrow
// - flag bit 7 shows direction on pulsed flag and zeroes other bits
// - flag bits 5, 6 or 7 set disable event bits 0-4
// - pulsed flag follows all flag bits, latched flag only bits 0-4
// - command bit 0 clears the counter, beating bits 1 and 2
// - command bit 1 loads low preset, bit 2 loads high preset
// - command bits 3 capture, 4 snapshot, 5 clear status and latched flag
// - command bit 7 clears presets, counter, capture, status, latched flag
// - command bytes are not stored, they act once only
// - live status bit layout; event bits stick until status clear
// - snapshot status uses the live status bit layout
// - every capture of the counter also copies live into snapshot status
// - range limit uses low and high presets as bounds, high in non recycle
// - modulo mode counts 0 to high preset, dividing by high preset plus one
// - multi byte registers move most significant byte first
// - range limit holds at a bound until direction reverses
module quad_counter_register_control (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic                        count_step,
   input  wire logic                        count_direction,
   input  wire quad_counter_pkg::count_mode_t count_mode,
   input  wire logic                        index_event,
   input  wire logic                        capture_req,
   input  wire logic                        power_loss_flag,
   input  wire logic                        link_clk,
   input  wire quad_counter_pkg::link_req_t link_req,
   output logic                             link_busy,
   output logic                             link_done,
   output logic [7:0]                       link_rdata,
   output logic                             pulsed_flag_out,
   output logic                             latched_flag_oe
);

   quad_counter_pkg::core_state_t core;
   quad_counter_pkg::core_state_t next_core;
   quad_counter_pkg::link_state_t lnk;
   quad_counter_pkg::link_state_t next_lnk;

   logic        link_rst_s1;
   logic        link_rst_s2;
   logic [31:0] mask;
   logic [31:0] lo;
   logic [31:0] hi;
   logic [31:0] cnt;
   logic [31:0] nxt;
   logic [31:0] sh;
   logic        step;
   logic        carry_event;
   logic        borrow_event;
   logic        match_low_event;
   logic        match_high_event;
   logic        master;
   logic        go;
   logic        multi;
   logic [1:0]  bi;
   logic [4:0]  ev;
   logic [7:0]  fs;

   function automatic logic [7:0] pick(logic [31:0] v, logic [1:0] i);
      pick = v[8*i +: 8];
   endfunction

   // core domain next state
   always_comb begin
      next_core = core;
      mask = quad_counter_pkg::FULL_MASK >> {core.count_setup[1:0], 3'h0};
      lo = core.preset_low & mask;
      hi = core.preset_high & mask;
      cnt = core.count_core;
      nxt = cnt;
      carry_event = 1'b0;
      borrow_event = 1'b0;
      step = count_step & ~core.count_setup[quad_counter_pkg::SETUP_GATE]
             & ~core.frozen;
      if (step) begin
         unique case (count_mode)
            quad_counter_pkg::MODE_FREE, quad_counter_pkg::MODE_NOREC: begin
               if (count_direction) begin
                  carry_event = (cnt == mask);
                  nxt = cnt + 32'h1;
               end else begin
                  borrow_event = (cnt == 32'h0);
                  nxt = cnt - 32'h1;
               end
            end
            quad_counter_pkg::MODE_RANGE: begin
               if (count_direction && cnt != hi) begin
                  nxt = cnt + 32'h1;
               end else if (!count_direction && cnt != lo) begin
                  nxt = cnt - 32'h1;
               end
            end
            quad_counter_pkg::MODE_MODN: begin
               if (count_direction) begin
                  carry_event = (cnt == hi);
                  nxt = carry_event ? 32'h0 : cnt + 32'h1;
               end else begin
                  borrow_event = (cnt == 32'h0);
                  nxt = borrow_event ? hi : cnt - 32'h1;
               end
            end
         endcase
      end
      nxt = nxt & mask;
      match_low_event = step & (nxt == lo)
         & ((count_mode != quad_counter_pkg::MODE_RANGE) | ~count_direction);
      match_high_event = step & (nxt == hi)
         & ((count_mode == quad_counter_pkg::MODE_FREE) | count_direction);
      next_core.count_core = nxt;
      if (step && count_mode == quad_counter_pkg::MODE_NOREC
          && ((match_high_event && count_direction) || borrow_event)) begin
         next_core.frozen = 1'b1;
      end

      // command strobes, one cycle after the byte is taken
      next_core.cmd_pend = 1'b0;
      master = core.cmd_pend & core.cmd[quad_counter_pkg::CMD_MASTER];
      if (master) begin
         next_core.preset_low = quad_counter_pkg::RESET_WORD;
         next_core.preset_high = quad_counter_pkg::RESET_WORD;
         next_core.count_core = quad_counter_pkg::RESET_WORD;
         next_core.count_capture = quad_counter_pkg::RESET_WORD;
         next_core.live_status = quad_counter_pkg::RESET_BYTE;
         next_core.snapshot_status = quad_counter_pkg::RESET_BYTE;
         next_core.latched = 1'b0;
         next_core.frozen = 1'b0;
      end else if (core.cmd_pend) begin
         if (core.cmd[quad_counter_pkg::CMD_CLR_COUNT]) begin
            next_core.count_core = quad_counter_pkg::RESET_WORD;
            next_core.frozen = 1'b0;
         end else if (core.cmd[quad_counter_pkg::CMD_LOAD_LOW]) begin
            next_core.count_core = lo;
            next_core.frozen = 1'b0;
         end else if (core.cmd[quad_counter_pkg::CMD_LOAD_HIGH]) begin
            next_core.count_core = hi;
            next_core.frozen = 1'b0;
         end
         if (core.cmd[quad_counter_pkg::CMD_SNAPSHOT]) begin
            next_core.snapshot_status = core.live_status;
         end
         if (core.cmd[quad_counter_pkg::CMD_CLR_STATUS]) begin
            next_core.live_status = quad_counter_pkg::RESET_BYTE;
            next_core.latched = 1'b0;
         end
      end
      if (!master && (capture_req || (core.cmd_pend
          && core.cmd[quad_counter_pkg::CMD_CAPTURE]))) begin
         next_core.count_capture = cnt;
         next_core.snapshot_status = core.live_status;
      end

      // byte link requests
      next_core.req_s1 = lnk.req_tgl;
      next_core.req_s2 = core.req_s1;
      go = core.req_s2 != core.ack_tgl;
      multi = (lnk.req.addr == quad_counter_pkg::REG_PRESET_LOW)
            | (lnk.req.addr == quad_counter_pkg::REG_PRESET_HIGH)
            | (lnk.req.addr == quad_counter_pkg::REG_CAPTURE)
            | (lnk.req.addr == quad_counter_pkg::REG_COUNT_VALUE);
      if (lnk.req.first) begin
         bi = multi ? ~core.count_setup[1:0] : 2'h0;
      end else begin
         bi = (core.idx != 2'h0) ? core.idx - 2'h1 : 2'h0;
      end
      sh = {core.shadow[23:0], lnk.req.wdata};
      if (go) begin
         next_core.ack_tgl = ~core.ack_tgl;
         next_core.idx = bi;
         if (lnk.req.rd) begin
            next_core.rdata = quad_counter_pkg::RESET_BYTE;
            unique case (lnk.req.addr)
               quad_counter_pkg::REG_COUNT_SETUP:
                  next_core.rdata = core.count_setup;
               quad_counter_pkg::REG_FLAG_SELECT:
                  next_core.rdata = core.flag_select;
               quad_counter_pkg::REG_PRESET_LOW:
                  next_core.rdata = pick(lo, bi);
               quad_counter_pkg::REG_PRESET_HIGH:
                  next_core.rdata = pick(hi, bi);
               quad_counter_pkg::REG_CAPTURE:
                  next_core.rdata = pick(core.count_capture & mask, bi);
               quad_counter_pkg::REG_SNAPSHOT:
                  next_core.rdata = core.snapshot_status;
               quad_counter_pkg::REG_LIVE_STATUS:
                  next_core.rdata = core.live_status;
               quad_counter_pkg::REG_COUNT_VALUE: begin
                  if (lnk.req.first) begin
                     next_core.shadow = cnt;
                     next_core.rdata = pick(cnt, bi);
                     if (!core.count_setup[quad_counter_pkg::SETUP_NO_SNAP])
                     begin
                        next_core.snapshot_status = core.live_status;
                     end
                     if (core.count_setup[quad_counter_pkg::SETUP_CLR_RD])
                     begin
                        next_core.live_status = quad_counter_pkg::RESET_BYTE;
                     end
                  end else begin
                     next_core.rdata = pick(core.shadow, bi);
                  end
               end
               default: next_core.rdata = quad_counter_pkg::RESET_BYTE;
            endcase
         end else begin
            unique case (lnk.req.addr)
               quad_counter_pkg::REG_COUNT_SETUP:
                  next_core.count_setup = lnk.req.wdata;
               quad_counter_pkg::REG_FLAG_SELECT:
                  next_core.flag_select = lnk.req.wdata[7]
                     ? quad_counter_pkg::FLAG_DIR_ONLY : lnk.req.wdata;
               quad_counter_pkg::REG_PRESET_LOW: begin
                  next_core.shadow = sh;
                  if (bi == 2'h0) begin
                     next_core.preset_low = sh & mask;
                  end
               end
               quad_counter_pkg::REG_PRESET_HIGH: begin
                  next_core.shadow = sh;
                  if (bi == 2'h0) begin
                     next_core.preset_high = sh & mask;
                  end
               end
               quad_counter_pkg::REG_COMMAND: begin
                  next_core.cmd = lnk.req.wdata;
                  next_core.cmd_pend = 1'b1;
               end
               default: next_core.cmd_pend = 1'b0;
            endcase
         end
      end

      // events set after clears so a set in the clear cycle survives
      next_core.live_status[quad_counter_pkg::ST_POWER_LOSS] =
         next_core.live_status[quad_counter_pkg::ST_POWER_LOSS]
         | power_loss_flag;
      next_core.live_status[quad_counter_pkg::ST_GATE] =
         ~core.count_setup[quad_counter_pkg::SETUP_GATE];
      next_core.live_status[quad_counter_pkg::ST_INDEX] =
         next_core.live_status[quad_counter_pkg::ST_INDEX] | index_event;
      next_core.live_status[quad_counter_pkg::ST_MATCH_LOW] =
         next_core.live_status[quad_counter_pkg::ST_MATCH_LOW]
         | match_low_event;
      next_core.live_status[quad_counter_pkg::ST_MATCH_HIGH] =
         next_core.live_status[quad_counter_pkg::ST_MATCH_HIGH]
         | match_high_event;
      next_core.live_status[quad_counter_pkg::ST_BORROW] =
         next_core.live_status[quad_counter_pkg::ST_BORROW] | borrow_event;
      next_core.live_status[quad_counter_pkg::ST_CARRY] =
         next_core.live_status[quad_counter_pkg::ST_CARRY] | carry_event;
      next_core.live_status[quad_counter_pkg::ST_DIR] = count_direction;

      // flag outputs
      fs = core.flag_select;
      ev = {index_event, match_high_event, match_low_event,
            borrow_event, carry_event};
      next_core.match_high_toggle = core.match_high_toggle
         ^ (fs[quad_counter_pkg::FLAG_MH_TGL] & match_high_event
            & count_direction);
      next_core.borrow_toggle = core.borrow_toggle
         ^ (fs[quad_counter_pkg::FLAG_BW_TGL] & borrow_event);
      if (fs[quad_counter_pkg::FLAG_DIR]) begin
         next_core.pulsed_active = ~count_direction;
      end else if (fs[6:5] != 2'h0) begin
         next_core.pulsed_active = ~(
            (fs[quad_counter_pkg::FLAG_MH_TGL] & core.match_high_toggle)
            | (fs[quad_counter_pkg::FLAG_BW_TGL] & core.borrow_toggle));
      end else begin
         next_core.pulsed_active = |(fs[4:0] & ev);
      end
      if (fs[7:5] == 3'h0 && (fs[4:0] & ev) != 5'h0) begin
         next_core.latched = 1'b1;
      end
      next_core.count_core = next_core.count_core
         & (quad_counter_pkg::FULL_MASK
            >> {next_core.count_setup[1:0], 3'h0});
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core <= '0;
      end else begin
         core <= next_core;
      end
   end

   // link domain: reset release and request capture
   always_ff @(posedge link_clk) begin
      link_rst_s1 <= rst_b;
      link_rst_s2 <= link_rst_s1;
   end

   always_comb begin
      next_lnk = lnk;
      next_lnk.ack_s1 = core.ack_tgl;
      next_lnk.ack_s2 = lnk.ack_s1;
      next_lnk.done = 1'b0;
      if (lnk.ack_s2 != lnk.ack_seen) begin
         next_lnk.ack_seen = lnk.ack_s2;
         next_lnk.rdata = core.rdata;
         next_lnk.done = 1'b1;
      end
      if (!link_busy && (link_req.rd || link_req.wr)) begin
         next_lnk.req = link_req;
         next_lnk.req_tgl = ~lnk.req_tgl;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_s2) begin
         lnk <= '0;
      end else begin
         lnk <= next_lnk;
      end
   end

   assign link_busy = lnk.req_tgl != lnk.ack_seen;
   assign link_done = lnk.done;
   assign link_rdata = lnk.rdata;
   assign pulsed_flag_out = ~core.pulsed_active;
   assign latched_flag_oe = core.latched;

   // checks
   a_gate_holds_count: assert property (
      @(posedge clk) disable iff (!rst_b)
      core.count_setup[quad_counter_pkg::SETUP_GATE] && !core.cmd_pend
      |=> $stable(core.count_core))
      else $error("counter moved while gated");
   a_clear_count_wins: assert property (
      @(posedge clk) disable iff (!rst_b)
      core.cmd_pend && core.cmd[0] && !core.cmd[7]
      |=> core.count_core == 32'h0)
      else $error("clear counter command lost");
   a_master_clears: assert property (@(posedge clk) disable iff (!rst_b)
      core.cmd_pend && core.cmd[7] |=> core.preset_low == 32'h0
      && core.preset_high == 32'h0 && core.count_capture == 32'h0
      && !core.latched)
      else $error("master clear incomplete");
   a_dir_forces_zero: assert property (
      @(posedge clk) disable iff (!rst_b)
      core.flag_select[7] |-> core.flag_select[6:0] == 7'h0)
      else $error("direction mode left other flag bits set");
   a_capture_pairs: assert property (@(posedge clk) disable iff (!rst_b)
      core.cmd_pend && core.cmd[3] && !core.cmd[7]
      |=> core.count_capture == $past(core.count_core)
      && core.snapshot_status == $past(core.live_status))
      else $error("capture without snapshot");
   a_cmd_one_shot: assert property (@(posedge clk) disable iff (!rst_b)
      core.cmd_pend |=> !core.cmd_pend)
      else $error("command acted twice");
   a_latch_source: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(core.latched) |-> $past(core.flag_select[7:5]) == 3'h0)
      else $error("latched flag set by a toggle or direction bit");
   a_width_masked: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 (core.count_core & ~mask) == 32'h0)
      else $error("counter uses bytes above the width");
   a_dir_on_flag: assert property (@(posedge clk) disable iff (!rst_b)
      core.flag_select[7] |=> pulsed_flag_out == $past(count_direction))
      else $error("direction not shown on pulsed flag");
   a_link_answer: assert property (@(posedge link_clk)
      disable iff (!link_rst_s2)
      !link_busy && (link_req.rd || link_req.wr) |-> ##[2:6] link_done)
      else $error("link byte not answered");

   c_read_copy_clear: cover property (@(posedge clk) disable iff (!rst_b)
      go && lnk.req.rd && lnk.req.first
      && lnk.req.addr == quad_counter_pkg::REG_COUNT_VALUE
      && core.count_setup[7:6] == 2'h1);
   c_master_clear: cover property (@(posedge clk) disable iff (!rst_b)
      core.cmd_pend && core.cmd[7]);
   c_preset_commit: cover property (@(posedge clk) disable iff (!rst_b)
      go && lnk.req.wr && bi == 2'h0 && core.count_setup[1:0] == 2'h0
      && lnk.req.addr == quad_counter_pkg::REG_PRESET_HIGH);
   c_latched_set: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(core.latched));

endmodule
`default_nettype wire

// ---- tb/link_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module link_host (
   input  wire logic                      link_clk,
   input  wire logic                      link_busy,
   input  wire logic                      link_done,
   input  wire logic [7:0]                link_rdata,
   output var  quad_counter_pkg::link_req_t link_req
);
   initial link_req = '0;
   // one byte per call; waits are bounded
   task automatic xfer(input logic w, input logic f, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
      int n;
      n = 0;
      @(negedge link_clk);
      while (link_busy !== 1'b0 && n < 20) begin
         @(negedge link_clk);
         n++;
      end
      link_req <= '{rd: !w, wr: w, first: f, addr: a, wdata: d};
      @(negedge link_clk);
      // rd and wr drop, first, address and data show the inverse of the last value
      link_req <= '{rd: 1'b0, wr: 1'b0, first: !f, addr: ~a, wdata: ~d};
      while (link_done !== 1'b1 && n < 20) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      q = link_rdata;
      ok = (n < 20);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                        clk;
   logic                        rst_b;
   logic                        link_clk;
   logic                        count_step;
   logic                        count_direction;
   logic                        link_busy;
   logic                        link_done;
   logic [7:0]                  link_rdata;
   logic                        pulsed_flag_out;
   logic                        latched_flag_oe;
   quad_counter_pkg::link_req_t link_req;
   int                          miscompares;
   int                          cmp_count;
   logic [31:0]                 v;
   logic                        cap;
   quad_counter_pkg::count_mode_t mode;

   initial clk = 1'b0;
   always #4 clk = ~clk;
   initial link_clk = 1'b0;
   always #62.5 link_clk = ~link_clk;

   quad_counter_register_control DUT (
      .clk(clk), .rst_b(rst_b), .count_step(count_step),
      .count_direction(count_direction),
      .count_mode(mode), .index_event(1'b0),
      .capture_req(cap), .power_loss_flag(1'b0), .link_clk(link_clk),
      .link_req(link_req), .link_busy(link_busy), .link_done(link_done),
      .link_rdata(link_rdata), .pulsed_flag_out(pulsed_flag_out),
      .latched_flag_oe(latched_flag_oe));

   link_host host (
      .link_clk(link_clk), .link_busy(link_busy), .link_done(link_done),
      .link_rdata(link_rdata), .link_req(link_req));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input int n);
      logic [7:0] b;
      logic       ok;
      v = '0;
      for (int i = n - 1; i >= 0; i--) begin
         host.xfer(w, i == n - 1, a, d[8*i +: 8], b, ok);
         v[8*i +: 8] = b;
         if (!ok) begin
            miscompares++;
            close_out();
         end
      end
   endtask

   task automatic rd(input string what, input logic [3:0] a, input int n,
                     input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, n);
      check(what, v, exp);
   endtask

   task automatic cmd(input logic [7:0] c);
      xfer(1'b1, quad_counter_pkg::REG_COMMAND, {24'h0, c}, 1);
      repeat (4) @(negedge clk);
   endtask

   task automatic step(input logic up, input int k);
      repeat (k) begin
         @(negedge clk);
         count_direction = up;
         count_step = 1'b1;
         @(negedge clk);
         count_step = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask

   initial begin
      miscompares = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      count_step = 1'b0;
      count_direction = 1'b1;
      cap = 1'b0;
      mode = quad_counter_pkg::MODE_FREE;
      // held in link cycles so the link side sees reset too
      repeat (5) @(negedge link_clk);
      @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge link_clk);
      rd("setup", quad_counter_pkg::REG_COUNT_SETUP, 1, 32'h0);
      rd("flags", quad_counter_pkg::REG_FLAG_SELECT, 1, 32'h0);
      rd("plow", quad_counter_pkg::REG_PRESET_LOW, 4, 32'h0);
      rd("capture", quad_counter_pkg::REG_CAPTURE, 4, 32'h0);
      rd("snap", quad_counter_pkg::REG_SNAPSHOT, 1, 32'h0);
      $display("reset test done");
      xfer(1'b1, quad_counter_pkg::REG_FLAG_SELECT, 32'hFF, 1);
      rd("flags", quad_counter_pkg::REG_FLAG_SELECT, 1, 32'h80);
      @(negedge clk) count_direction = 1'b0;
      repeat (2) @(negedge clk);
      check("pulsed", {31'h0, pulsed_flag_out}, 32'h0);
      count_direction = 1'b1;
      xfer(1'b1, quad_counter_pkg::REG_COUNT_SETUP, 32'h02, 1);
      rd("setup", quad_counter_pkg::REG_COUNT_SETUP, 1, 32'h02);
      xfer(1'b1, quad_counter_pkg::REG_PRESET_LOW, 32'h1234, 2);
      rd("plow", quad_counter_pkg::REG_PRESET_LOW, 2, 32'h1234);
      xfer(1'b1, quad_counter_pkg::REG_PRESET_HIGH, 32'h00A0, 2);
      cmd(8'h02);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h1234);
      cmd(8'h04);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h00A0);
      cmd(8'h43);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h0);
      $display("load test done");
      step(1'b1, 3);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h3);
      xfer(1'b1, quad_counter_pkg::REG_COUNT_SETUP, 32'h06, 1);
      step(1'b1, 2);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h3);
      xfer(1'b1, quad_counter_pkg::REG_COUNT_SETUP, 32'h02, 1);
      $display("gate test done");
      xfer(1'b1, quad_counter_pkg::REG_FLAG_SELECT, 32'h42, 1);
      cmd(8'h01);
      step(1'b0, 1);
      check("latched", {31'h0, latched_flag_oe}, 32'h0);
      cmd(8'h21);
      xfer(1'b1, quad_counter_pkg::REG_FLAG_SELECT, 32'h02, 1);
      step(1'b0, 1);
      check("latched", {31'h0, latched_flag_oe}, 32'h1);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'hFFFF);
      xfer(1'b1, quad_counter_pkg::REG_COUNT_SETUP, 32'h42, 1);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'hFFFF);
      xfer(1'b0, quad_counter_pkg::REG_SNAPSHOT, 32'h0, 1);
      check("snap", v & 32'h20, 32'h20);
      xfer(1'b0, quad_counter_pkg::REG_LIVE_STATUS, 32'h0, 1);
      check("live", v & 32'h20, 32'h0);
      cmd(8'h20);
      check("latched", {31'h0, latched_flag_oe}, 32'h0);
      $display("status test done");
      cmd(8'h08);
      rd("capture", quad_counter_pkg::REG_CAPTURE, 2, 32'hFFFF);
      cmd(8'h80);
      rd("plow", quad_counter_pkg::REG_PRESET_LOW, 2, 32'h0);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 2, 32'h0);
      rd("capture", quad_counter_pkg::REG_CAPTURE, 2, 32'h0);
      rd("command", quad_counter_pkg::REG_COMMAND, 1, 32'h0);
      rd("unmapped", 4'hF, 1, 32'h0);
      $display("clear test done");
      xfer(1'b1, quad_counter_pkg::REG_COUNT_SETUP, 32'h80, 1);
      xfer(1'b1, quad_counter_pkg::REG_PRESET_HIGH, 32'h2, 4);
      rd("phigh", quad_counter_pkg::REG_PRESET_HIGH, 4, 32'h2);
      @(negedge clk) mode = quad_counter_pkg::MODE_RANGE;
      step(1'b1, 4);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 4, 32'h2);
      step(1'b0, 1);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 4, 32'h1);
      @(negedge clk) mode = quad_counter_pkg::MODE_MODN;
      step(1'b1, 2);
      rd("count", quad_counter_pkg::REG_COUNT_VALUE, 4, 32'h0);
      step(1'b1, 1);
      @(negedge clk) cap = 1'b1;
      @(negedge clk) cap = 1'b0;
      rd("capture", quad_counter_pkg::REG_CAPTURE, 4, 32'h1);
      xfer(1'b0, quad_counter_pkg::REG_SNAPSHOT, 32'h0, 1);
      check("snap", v & 32'h40, 32'h40);
      $display("mode test done");
      close_out();
   end
endmodule
`default_nettype wire
